// ---- include/xbc_cfg.svh ----
// Purpose: Constants of the external bus controller
// Assumes: Included by bare name
// Notes: Counts, bit positions, a kind code and a reset value
`ifndef XBC_CFG_SVH
`define XBC_CFG_SVH
`define XBC_NWIN 4
`define XBC_FIFO_DEPTH 8
`define XBC_DFLT_RST 11'h000
`define XBC_STRAP_KIND_LSB 6
`define XBC_UA_LSB 3
`define XBC_CS_LSB 0
`define XBC_KIND_MUX_BIT 0
`define XBC_KIND_W16_BIT 1
`define XBC_KIND_MUX8 2'h1
`define XBC_SEG_LSB 16
`endif

// ---- include/xbc_pkg.sv ----
// Purpose: Types of the external bus controller
// Assumes: Nothing
// Notes: Bus kind bit 1 is 16-bit data, bit 0 is multiplexed
`default_nettype none
package xbc_pkg;
    typedef struct packed {
        logic bus_active;
        logic [1:0] bus_kind;
        logic [3:0] waitstates;
        logic ready_en;
        logic ale_ext;
        logic rw_delay;
        logic cs_en;
    } xbc_bus_cfg_t;
    typedef struct packed {
        logic [11:0] base;
        logic [3:0] size;
    } xbc_range_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic write;
        logic word;
        logic internal;
    } xbc_req_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ALE = 3'h1,
        ST_LATCH = 3'h2,
        ST_DELAY = 3'h3,
        ST_CMD = 3'h4,
        ST_END = 3'h6
    } xbc_state_t;
endpackage
`default_nettype wire

// ---- logic/xbc_fifo.sv ----
// Purpose: Request buffer in front of the bus sequencer
// Assumes: One clock, synchronous reset
// Notes: Depth must be a power of two
`default_nettype none
module xbc_fifo #(
    parameter int WIDTH = 43,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule // xbc_fifo
`default_nettype wire

// ---- logic/xbc_window_match.sv ----
// Purpose: Address window hit test
// Assumes: Window granule is 4 KByte
// Notes: Size 0 switches the window off; size n spans 2**n granules
`default_nettype none
module xbc_window_match (
    input wire logic [11:0] addr_hi,
    input wire xbc_pkg::xbc_range_t range,
    output logic hit
);
    logic [11:0] mask;
    assign mask = 12'hfff << range.size;
    assign hit = (range.size != 4'h0) && (((addr_hi ^ range.base) & mask) == 12'h000);
endmodule // xbc_window_match
`default_nettype wire

// ---- logic/xbc_bus_ctrl.sv ----
// Purpose: External bus controller, multiplexed and demultiplexed cycles
// Assumes: Pins ad_in, ready_n, straps are asynchronous and synchronised here
// Notes: Reads keep the strobe low three clocks at least, covering the data sync
`include "xbc_cfg.svh"
`default_nettype none
// Function
// R1 - Four windows, default config covers the rest
// R2 - Window config sets mode, width, timing
// R3 - Boot pin high: default config cleared
// R4 - Single-chip external access raises trap
// R5 - Software may still enable default bus
// R6 - Bus only when active; kind code selects
// R7 - Boot pin low: kind strapped from port
// R8 - Software programs window bus kinds
// R9 - In-segment address on muxed or demux port
// R10 - Segmentation fields captured at reset
// R11 - Segmentation-off decides pointer save
// R12 - Mux: 8-bit keeps high byte address
// R13 - Upper address lines driven continuously
// R14 - ALE and address, then command strobe
// R15 - Latch captures address at ALE fall
// R16 - Device drives write data in command
// R17 - Read: latch data, then release strobe
// R18 - Write data held until next cycle
// R19 - ALE only for external cycles
// R20 - Ready ignored during waitstates
// R21 - Strobes active low, high when idle
module xbc_bus_ctrl #(
    parameter int NWIN = `XBC_NWIN,
    parameter int DEPTH = `XBC_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic req_valid,
    output logic req_ready,
    input wire xbc_pkg::xbc_req_t req,
    output logic rsp_valid,
    output logic rsp_trap,
    output logic [15:0] rsp_rdata,
    input wire logic dflt_cfg_wr,
    input wire xbc_pkg::xbc_bus_cfg_t dflt_cfg_wdata,
    output xbc_pkg::xbc_bus_cfg_t default_window_cfg,
    input wire xbc_pkg::xbc_bus_cfg_t window_bus_cfg [NWIN],
    input wire xbc_pkg::xbc_range_t window_range_sel [NWIN],
    input wire logic segmentation_off,
    output logic save_csp,
    input wire logic boot_source_select,
    input wire logic [7:0] reset_config_high_byte,
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic [1:0] ad_oe,
    output logic [15:0] demux_addr_out,
    output logic [7:0] addr_hi_out,
    output logic [NWIN:0] cs_n,
    output logic ale,
    output logic rd_n,
    output logic wr_lo_n,
    output logic wr_hi_n,
    input wire logic ready_n
);
    localparam int QW = $bits(xbc_pkg::xbc_req_t);
    xbc_pkg::xbc_state_t state_reg;
    xbc_pkg::xbc_req_t fifo_q;
    xbc_pkg::xbc_req_t cur_reg;
    xbc_pkg::xbc_bus_cfg_t cfg_reg;
    xbc_pkg::xbc_bus_cfg_t sel_cfg;
    logic [2:0] sel_idx;
    logic [2:0] cs_idx_reg;
    logic [NWIN-1:0] hit;
    logic fifo_valid;
    logic fifo_pop;
    logic [3:0] cnt_reg;
    logic hi_reg;
    logic boot_s1, boot_s2;
    logic rdy_s1, rdy_s2;
    logic [15:0] ad_s1, ad_s2;
    logic [7:0] rc_s1, rc_s2;
    logic [1:0] ua_cnt_reg;
    logic [2:0] cs_cnt_reg;
    logic start;
    logic trap;
    logic launch;
    logic launch_mux;
    logic [15:0] launch_a;
    logic [15:0] cur_a;
    logic cmd_go;
    logic cmd_done;
    logic split;
    logic w16;
    logic lo_en;
    logic hi_en;
    logic [7:0] wbyte;

    // Requests queue here so the CPU side can post ahead of slow cycles
    xbc_fifo #(
        .WIDTH(QW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_q)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NWIN; gi++)
        begin : g_win
            xbc_window_match u_match (
                .addr_hi(fifo_q.addr[23:12]),
                .range(window_range_sel[gi]),
                .hit(hit[gi])
            );
        end
    endgenerate

    // Lowest numbered window wins an overlap
    always_comb
    begin
        sel_cfg = default_window_cfg; // R1
        sel_idx = 3'h0;
        for (int i = NWIN - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                sel_cfg = window_bus_cfg[i]; // R2
                sel_idx = 3'(i + 1);
            end
        end
    end

    // Pins are asynchronous to mclk
    always_ff @(posedge mclk)
    begin
        boot_s1 <= boot_source_select;
        boot_s2 <= boot_s1;
        rdy_s1 <= ready_n;
        rdy_s2 <= rdy_s1;
        ad_s1 <= ad_in;
        ad_s2 <= ad_s1;
        rc_s1 <= reset_config_high_byte;
        rc_s2 <= rc_s1;
    end

    // Straps are sampled throughout reset; the last value before release sticks
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            if (boot_s2)
                default_window_cfg <= `XBC_DFLT_RST; // R3
            else
            begin
                default_window_cfg <= `XBC_DFLT_RST;
                default_window_cfg.bus_active <= 1'b1;
                default_window_cfg.bus_kind <= ad_s2[`XBC_STRAP_KIND_LSB +: 2]; // R7
            end
        end
        else if (dflt_cfg_wr)
            default_window_cfg <= dflt_cfg_wdata; // R5
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ua_cnt_reg <= rc_s2[`XBC_UA_LSB +: 2]; // R10
            cs_cnt_reg <= rc_s2[`XBC_CS_LSB +: 3]; // R10
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            save_csp <= 1'b0;
        else
            save_csp <= !segmentation_off; // R11
    end

    assign fifo_pop = (state_reg == xbc_pkg::ST_IDLE) && fifo_valid;
    assign start = fifo_pop && !fifo_q.internal && sel_cfg.bus_active; // R6
    assign trap = fifo_pop && !fifo_q.internal && !sel_cfg.bus_active; // R4
    assign launch = start || (state_reg == xbc_pkg::ST_END);
    assign launch_mux = (state_reg == xbc_pkg::ST_END) ? cfg_reg.bus_kind[`XBC_KIND_MUX_BIT]
        : sel_cfg.bus_kind[`XBC_KIND_MUX_BIT];
    assign launch_a = (state_reg == xbc_pkg::ST_END) ? {cur_reg.addr[15:1], 1'b1}
        : {fifo_q.addr[15:1], fifo_q.addr[0] && !fifo_q.word};
    assign cur_a = {cur_reg.addr[15:1], hi_reg || (cur_reg.addr[0] && !cur_reg.word)};
    assign w16 = cfg_reg.bus_kind[`XBC_KIND_W16_BIT];
    assign cmd_go = (state_reg == xbc_pkg::ST_DELAY) && (cnt_reg == 4'h0);
    assign cmd_done = (state_reg == xbc_pkg::ST_CMD) && (cnt_reg == 4'h0)
        && !(cfg_reg.ready_en && rdy_s2); // R20
    assign split = !w16 && cur_reg.word && !hi_reg;
    assign lo_en = !w16 || cur_reg.word || !cur_reg.addr[0];
    assign hi_en = w16 && (cur_reg.word || cur_reg.addr[0]);
    assign wbyte = cur_a[0] ? cur_reg.wdata[15:8] : cur_reg.wdata[7:0];

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_reg <= xbc_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            cur_reg <= '0;
            cfg_reg <= '0;
            hi_reg <= 1'b0;
            cs_idx_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                xbc_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        cur_reg <= fifo_q;
                        cfg_reg <= sel_cfg;
                        cs_idx_reg <= sel_idx;
                        hi_reg <= 1'b0;
                        cnt_reg <= {3'h0, sel_cfg.ale_ext};
                        state_reg <= xbc_pkg::ST_ALE;
                    end
                end
                xbc_pkg::ST_ALE:
                begin
                    if (cnt_reg != 4'h0)
                        cnt_reg <= cnt_reg - 4'h1;
                    else
                        state_reg <= xbc_pkg::ST_LATCH; // R14
                end
                xbc_pkg::ST_LATCH:
                begin
                    cnt_reg <= {3'h0, cfg_reg.rw_delay};
                    state_reg <= xbc_pkg::ST_DELAY;
                end
                xbc_pkg::ST_DELAY:
                begin
                    if (cnt_reg != 4'h0)
                        cnt_reg <= cnt_reg - 4'h1;
                    else
                    begin
                        // Read data passes two sync flops, so it must be sampled inside the strobe
                        cnt_reg <= (cur_reg.write || cfg_reg.waitstates > 4'h1) ? cfg_reg.waitstates : 4'h2;
                        state_reg <= xbc_pkg::ST_CMD;
                    end
                end
                xbc_pkg::ST_CMD:
                begin
                    if (cnt_reg != 4'h0)
                        cnt_reg <= cnt_reg - 4'h1; // R20
                    else if (cmd_done)
                    begin
                        hi_reg <= split;
                        state_reg <= split ? xbc_pkg::ST_END : xbc_pkg::ST_IDLE;
                    end
                end
                xbc_pkg::ST_END:
                begin
                    cnt_reg <= {3'h0, cfg_reg.ale_ext};
                    state_reg <= xbc_pkg::ST_ALE;
                end
                default:
                    state_reg <= xbc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            ale <= 1'b0;
        else if (launch)
            ale <= 1'b1; // R19
        else if (state_reg == xbc_pkg::ST_ALE && cnt_reg == 4'h0)
            ale <= 1'b0; // R15
    end

    // Shared port: address at launch, data from latch phase, held while idle
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ad_out <= 16'h0000;
            ad_oe <= 2'h0;
            demux_addr_out <= 16'h0000;
        end
        else if (launch)
        begin
            demux_addr_out <= launch_a; // R9
            ad_out <= launch_a; // R9
            ad_oe <= launch_mux ? 2'h3 : 2'h0; // R14
        end
        else if (state_reg == xbc_pkg::ST_LATCH)
        begin
            if (!w16)
            begin
                ad_out[7:0] <= wbyte; // R16
                ad_oe[0] <= cur_reg.write; // R17
                ad_oe[1] <= cfg_reg.bus_kind[`XBC_KIND_MUX_BIT]; // R12
            end
            else
            begin
                ad_out <= cur_reg.word ? cur_reg.wdata : {wbyte, wbyte}; // R16
                ad_oe <= {2{cur_reg.write}}; // R17
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rd_n <= 1'b1;
            wr_lo_n <= 1'b1;
            wr_hi_n <= 1'b1;
        end
        else if (cmd_go)
        begin
            rd_n <= cur_reg.write; // R14
            wr_lo_n <= !(cur_reg.write && lo_en);
            wr_hi_n <= !(cur_reg.write && hi_en);
        end
        else if (cmd_done)
        begin
            rd_n <= 1'b1; // R21
            wr_lo_n <= 1'b1; // R18
            wr_hi_n <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            rsp_trap <= 1'b0;
            rsp_rdata <= 16'h0000;
        end
        else
        begin
            rsp_valid <= (fifo_pop && !start) || (cmd_done && !split);
            rsp_trap <= trap; // R4
            if (cmd_done && !cur_reg.write)
            begin
                if (w16)
                    rsp_rdata <= ad_s2; // R17
                else if (cur_a[0])
                    rsp_rdata[15:8] <= ad_s2[7:0];
                else
                    rsp_rdata[7:0] <= ad_s2[7:0];
            end
        end
    end

    // Upper lines stay put between cycles so no external latch is needed
    always_ff @(posedge mclk)
    begin
        if (srst)
            addr_hi_out <= 8'h00;
        else if (start)
            addr_hi_out <= segmentation_off ? 8'h00
                : fifo_q.addr[`XBC_SEG_LSB +: 8] & (8'hff >> {ua_cnt_reg, 1'b0}); // R13
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            cs_n <= '1;
        else if (start && sel_cfg.cs_en && sel_idx < cs_cnt_reg && !segmentation_off)
            cs_n <= ~((NWIN+1)'(1) << sel_idx); // R10
        else if (cmd_done && !split)
            cs_n <= '1;
    end

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence ale_start_s;
        $rose(ale) ##0 (state_reg == xbc_pkg::ST_ALE);
    endsequence
    sequence strobe_low_s;
        !rd_n || !wr_lo_n || !wr_hi_n;
    endsequence
    property ale_then_cmd_p;
        ale_start_s |-> ##[3:5] (state_reg == xbc_pkg::ST_CMD);
    endproperty

    dflt_clear_a: assert property ($fell(srst) && $past(boot_s2) |-> default_window_cfg == '0) // R3
        else $error("default config not cleared");
    trap_no_cycle_a: assert property (trap |=> rsp_trap && rsp_valid && !ale) // R4
        else $error("trap started a bus cycle");
    active_only_a: assert property ($rose(ale) |-> cfg_reg.bus_active) // R6
        else $error("cycle on inactive bus");
    ale_cmd_order_a: assert property (ale_then_cmd_p) // R14
        else $error("command not after ale");
    cmd_after_ale_a: assert property (strobe_low_s |-> !ale && $past(!ale)) // R14
        else $error("strobe overlaps ale");
    internal_quiet_a: assert property (fifo_pop && fifo_q.internal |=> !ale && rsp_valid) // R19
        else $error("ale on internal access");
    wait_ignore_a: assert property (state_reg == xbc_pkg::ST_CMD && cnt_reg != 4'h0 |=> state_reg == xbc_pkg::ST_CMD) // R20
        else $error("cycle ended in waitstate");
    idle_high_a: assert property (state_reg == xbc_pkg::ST_IDLE |-> rd_n && wr_lo_n && wr_hi_n) // R21
        else $error("strobe active when idle");
    data_hold_a: assert property (state_reg == xbc_pkg::ST_IDLE && $past(state_reg == xbc_pkg::ST_IDLE) |-> $stable(ad_out) && $stable(ad_oe)) // R18
        else $error("bus changed while idle");
    mux8_high_a: assert property (state_reg == xbc_pkg::ST_CMD && cfg_reg.bus_kind == `XBC_KIND_MUX8 |-> ad_oe[1] && ad_out[15:8] == cur_a[15:8]) // R12
        else $error("8-bit mux high byte lost");
endmodule // xbc_bus_ctrl
`default_nettype wire

// ---- verification/xbc_ext_mem.sv ----
// Purpose: External memory with address latch on the far side of the bus
// Assumes: Byte store; the bench tells the width and address mode in force
// Notes: Released lines show the inverse of the last value, so stale data never passes
`default_nettype none
module xbc_ext_mem (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] strap,
    input wire logic wide,
    input wire logic demux,
    input wire logic [7:0] rdy_dly,
    input wire logic [15:0] ad_wire,
    input wire logic [1:0] ad_oe,
    input wire logic [15:0] demux_addr,
    input wire logic [7:0] addr_hi,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_lo_n,
    input wire logic wr_hi_n,
    output logic [15:0] drive,
    output logic ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [logic [23:0]];
    logic [15:0] lat = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic open_c = 1'b0;
    logic [7:0] wait_c = 8'h00;
    logic [23:0] a;
    assign a = {addr_hi, demux ? demux_addr : lat};
    function automatic logic [7:0] rb(input logic [23:0] x);
        return mem.exists(x) ? mem[x] : 8'h00;
    endfunction
    always @(negedge ale)
    begin
        lat = ad_wire;
        open_c = 1'b1;
    end
    always @(posedge wr_lo_n)
    begin
        if (!srst)
            mem[a] = ad_wire[7:0];
        open_c = 1'b0;
    end
    always @(posedge wr_hi_n)
    begin
        if (!srst)
            mem[a | 24'h000001] = ad_wire[15:8];
        open_c = 1'b0;
    end
    always @(posedge rd_n)
        open_c = 1'b0;
    // Drives only while the device has let go and no write strobe is low
    always_comb
    begin
        if (srst)
            drive = {8'h00, strap};
        else if (open_c && !ad_oe[0] && wr_lo_n && wr_hi_n)
            drive = wide ? {rb(a | 24'h000001), rb(a & 24'hfffffe)} : {~last[15:8], rb(a)};
        else
            drive = ~last;
    end
    always_ff @(posedge mclk)
    begin
        last <= drive;
        if (rd_n && wr_lo_n && wr_hi_n)
            wait_c <= 8'h00;
        else if (wait_c != 8'hff)
            wait_c <= wait_c + 8'h01;
    end
    // Pulled up outside a command; slow mode holds it off for rdy_dly cycles
    assign ready_n = (rd_n && wr_lo_n && wr_hi_n) || wait_c < rdy_dly;
endmodule // xbc_ext_mem
`default_nettype wire

// ---- verification/xbc_bus_ctrl_tb.sv ----
// Purpose: Self-checking bench of the external bus controller
// Assumes: Memory model on the shared port, bench drives CPU side
// Notes: Outputs are sampled on the falling edge, inputs driven on the rising one
`default_nettype none
module xbc_bus_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, srst, req_valid, req_ready, rsp_valid, rsp_trap, dflt_cfg_wr;
    logic segmentation_off, save_csp, boot_source_select, ale, rd_n, wr_lo_n, wr_hi_n, ready_n;
    xbc_pkg::xbc_req_t req;
    xbc_pkg::xbc_bus_cfg_t dflt_cfg_wdata, default_window_cfg;
    xbc_pkg::xbc_bus_cfg_t window_bus_cfg [4];
    xbc_pkg::xbc_range_t window_range_sel [4];
    logic [15:0] rsp_rdata, ad_in, ad_out, demux_addr_out, drive, rd;
    logic [7:0] reset_config_high_byte, addr_hi_out, strap, rdy_dly;
    logic [1:0] ad_oe;
    logic [4:0] cs_n;
    logic wide, demux, tr, full;
    int miscompares = 0, checks_done = 0, ale_cnt = 0, ale_w = 0, stb_w = 0, cur_a = 0, cur_s = 0;
    int n0, i, k;
    // Wire level of the shared port: whoever enables a byte owns it
    assign ad_in = {ad_oe[1] ? ad_out[15:8] : drive[15:8], ad_oe[0] ? ad_out[7:0] : drive[7:0]};
    xbc_bus_ctrl xbc_bus_ctrl_i (.mclk, .srst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_trap,
        .rsp_rdata, .dflt_cfg_wr, .dflt_cfg_wdata, .default_window_cfg, .window_bus_cfg,
        .window_range_sel, .segmentation_off, .save_csp, .boot_source_select, .reset_config_high_byte,
        .ad_in, .ad_out, .ad_oe, .demux_addr_out, .addr_hi_out, .cs_n, .ale, .rd_n, .wr_lo_n,
        .wr_hi_n, .ready_n);
    xbc_ext_mem xbc_ext_mem_i (.mclk(mclk), .srst(srst), .strap(strap), .wide(wide), .demux(demux),
        .rdy_dly(rdy_dly), .ad_wire(ad_in), .ad_oe(ad_oe), .demux_addr(demux_addr_out),
        .addr_hi(addr_hi_out), .ale(ale), .rd_n(rd_n), .wr_lo_n(wr_lo_n), .wr_hi_n(wr_hi_n),
        .drive(drive), .ready_n(ready_n));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Pulse count and width of the latch strobe, width of the command strobes
    always @(negedge mclk)
    begin
        if (ale)
            cur_a++;
        else if (cur_a != 0)
        begin
            ale_cnt++;
            ale_w = cur_a;
            cur_a = 0;
        end
        if (!rd_n || !wr_lo_n || !wr_hi_n)
            cur_s++;
        else if (cur_s != 0)
        begin
            stb_w = cur_s;
            cur_s = 0;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic xbc_pkg::xbc_bus_cfg_t cfg(input logic [1:0] kd, input logic [3:0] w,
        input logic r, input logic x);
        return '{1'b1, kd, w, r, x, 1'b0, 1'b1};
    endfunction
    task automatic do_reset(input logic b, input logic [7:0] s, input logic [7:0] rc);
        @(posedge mclk);
        srst <= 1'b1;
        boot_source_select <= b;
        strap <= s;
        reset_config_high_byte <= rc;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
    endtask
    // One request, held until taken, then waits for its answer
    task automatic access(input logic [23:0] a, input logic [15:0] wd, input logic w, input logic wo,
        input logic in, output logic [15:0] r, output logic t);
        @(posedge mclk);
        req <= '{a, wd, w, wo, in};
        req_valid <= 1'b1;
        @(negedge mclk);
        for (k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge mclk);
        @(posedge mclk);
        req_valid <= 1'b0;
        @(negedge mclk);
        for (k = 0; k < 400 && rsp_valid !== 1'b1; k++) @(negedge mclk);
        r = rsp_rdata;
        t = rsp_trap;
    endtask
    task automatic set_dflt(input xbc_pkg::xbc_bus_cfg_t c);
        @(posedge mclk);
        dflt_cfg_wr <= 1'b1;
        dflt_cfg_wdata <= c;
        @(posedge mclk);
        dflt_cfg_wr <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic width_case(input xbc_pkg::xbc_bus_cfg_t c, input logic [7:0] d, input int lo, input int hi);
        set_dflt(c);
        rdy_dly = d;
        access(24'h000400, 16'h0000, 1'b0, 1'b1, 1'b0, rd, tr);
        @(negedge mclk);
        check(stb_w >= lo && stb_w <= hi, 1'b1);
    endtask
    initial
    begin
        {srst, req_valid, dflt_cfg_wr, segmentation_off, wide, demux} = 6'h22;
        {boot_source_select, strap, reset_config_high_byte, rdy_dly} = 25'h0;
        req = '0;
        dflt_cfg_wdata = '0;
        window_bus_cfg = '{default: '0};
        window_range_sel = '{default: '0};
        do_reset(1'b1, 8'h00, 8'h05);
        @(negedge mclk);
        check(default_window_cfg, 11'h000);
        n0 = ale_cnt;
        access(24'h000200, 16'h1111, 1'b1, 1'b1, 1'b0, rd, tr);
        check(tr, 1'b1);
        access(24'h000200, 16'h0000, 1'b0, 1'b1, 1'b1, rd, tr);
        check(tr, 1'b0);
        check(ale_cnt - n0, 0);
        check({cs_n, rd_n, wr_lo_n, wr_hi_n}, 8'hff);
        $display("test single_chip done");
        set_dflt(cfg(2'h3, 4'h0, 1'b0, 1'b0));
        check(default_window_cfg, cfg(2'h3, 4'h0, 1'b0, 1'b0));
        n0 = ale_cnt;
        access(24'h000200, 16'h1234, 1'b1, 1'b1, 1'b0, rd, tr);
        @(negedge mclk);
        check({ad_oe, ad_out}, {2'h3, 16'h1234});
        access(24'h000200, 16'h0000, 1'b0, 1'b1, 1'b0, rd, tr);
        check(rd, 16'h1234);
        check(ale_cnt - n0, 2);
        check(ad_oe, 2'h0);
        access(24'h000203, 16'h5a5a, 1'b1, 1'b0, 1'b0, rd, tr);
        access(24'h000202, 16'h0000, 1'b0, 1'b1, 1'b0, rd, tr);
        check(rd, 16'h5a00);
        $display("test default_mux16 done");
        width_case(cfg(2'h3, 4'h3, 1'b0, 1'b0), 8'h00, 4, 4);
        width_case(cfg(2'h3, 4'h0, 1'b0, 1'b1), 8'h00, 3, 3);
        check(ale_w, 2);
        width_case(cfg(2'h3, 4'h2, 1'b1, 1'b0), 8'h00, 3, 8);
        width_case(cfg(2'h3, 4'h0, 1'b1, 1'b0), 8'h06, 7, 12);
        rdy_dly = 8'h00;
        $display("test cycle_length done");
        @(posedge mclk);
        window_bus_cfg[0] <= cfg(2'h1, 4'h0, 1'b0, 1'b0);
        window_range_sel[0] <= '{12'h100, 4'h4};
        window_bus_cfg[1] <= cfg(2'h2, 4'h0, 1'b0, 1'b0);
        window_range_sel[1] <= '{12'h200, 4'h4};
        wide = 1'b0;
        n0 = ale_cnt;
        access(24'h100010, 16'hbeef, 1'b1, 1'b1, 1'b0, rd, tr);
        access(24'h100010, 16'h0000, 1'b0, 1'b1, 1'b0, rd, tr);
        check(rd, 16'hbeef);
        check(ale_cnt - n0, 4);
        check(addr_hi_out, 8'h10);
        wide = 1'b1;
        demux = 1'b1;
        n0 = ale_cnt;
        access(24'h200100, 16'hc0de, 1'b1, 1'b1, 1'b0, rd, tr);
        access(24'h200100, 16'h0000, 1'b0, 1'b1, 1'b0, rd, tr);
        check(rd, 16'hc0de);
        check(demux_addr_out, 16'h0100);
        check(ale_cnt - n0, 2);
        demux = 1'b0;
        $display("test windows done");
        set_dflt(cfg(2'h3, 4'h0, 1'b1, 1'b0));
        rdy_dly = 8'h28;
        @(posedge mclk);
        req <= '{24'h000300, 16'h0000, 1'b1, 1'b1, 1'b0};
        req_valid <= 1'b1;
        n0 = 0;
        full = 1'b0;
        for (i = 0; i < 20 && !full; i++)
        begin
            @(negedge mclk);
            if (req_ready === 1'b0)
                full = 1'b1;
            else
                n0++;
            @(posedge mclk);
        end
        req_valid <= 1'b0;
        check({full, n0 >= 8 && n0 <= 9}, 2'h3);
        rdy_dly = 8'h00;
        i = 0;
        for (k = 0; k < 3000 && i < n0; k++)
        begin
            @(negedge mclk);
            if (rsp_valid === 1'b1)
                i++;
        end
        check(i, n0);
        $display("test buffer done");
        @(posedge mclk);
        segmentation_off <= 1'b1;
        repeat (3) @(negedge mclk);
        check(save_csp, 1'b0);
        segmentation_off <= 1'b0;
        repeat (3) @(negedge mclk);
        check(save_csp, 1'b1);
        do_reset(1'b0, 8'h80, 8'h08);
        @(negedge mclk);
        check(default_window_cfg, 11'h600);
        demux = 1'b1;
        access(24'h450000, 16'h0000, 1'b0, 1'b1, 1'b0, rd, tr);
        check(addr_hi_out, 8'h05);
        $display("test strap_reset done");
        final_report();
    end
    initial
    begin
        #400000;
        miscompares++;
        final_report();
    end
endmodule // xbc_bus_ctrl_tb
`default_nettype wire
